// >>> inc/wwd_pkg.sv
package wwd_pkg;
  // Counter and prescaler geometry
  localparam int CNT_W = 12;
  localparam int PSC_W = 3;
  localparam int PRE_W = 7;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RELOAD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DELTA = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_KICK = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_PROT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h1c;

  // Control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PSC_LSB = 4;
  localparam int CTRL_DBG_BIT = 8;

  // Status and mask fields
  localparam int ST_W = 3;
  localparam int ST_UNDERFLOW = 0;
  localparam int ST_EARLY = 1;
  localparam int ST_LOCKED_WR = 2;

  // Keys
  localparam logic [15:0] KICK_KEY = 16'hca5e;
  localparam logic [15:0] PROT_KEY = 16'h51a7;
  localparam int PROT_KEY_LSB = 16;

  // Reset values
  localparam logic [CNT_W-1:0] RELOAD_RST = 12'hfff;
  localparam logic [CNT_W-1:0] DELTA_RST = 12'hfff;
  localparam logic [PSC_W-1:0] PSC_RST = 3'h0;

  // Prescaler wrap point: divide by 2**psc
  function automatic logic [PRE_W-1:0] pre_limit(input logic [PSC_W-1:0] psc);
    logic [PRE_W:0] one_hot;
    one_hot = '0;
    one_hot[psc] = 1'b1;
    pre_limit = PRE_W'(one_hot - 1'b1);
  endfunction
endpackage

// >>> inc/wwd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wwd_if;
  import wwd_pkg::*;
  logic tick;
  logic run;
  logic reload;
  logic [PSC_W-1:0] psc;
  logic [CNT_W-1:0] reload_val;
  logic [CNT_W-1:0] count;
  logic underflow;

  modport ctl(output tick, run, reload, psc, reload_val, input count, underflow);
  modport cnt(input tick, run, reload, psc, reload_val, output count, underflow);
endinterface
`default_nettype wire

// >>> core/wwd_counter.sv
`timescale 1ns/1ps
`default_nettype none
module wwd_counter (
  input wire logic clk,
  input wire logic rst_b,
  wwd_if.cnt cif
);
  import wwd_pkg::*;

  logic [PRE_W-1:0] pre_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic uf_ff;
  logic step;

  // At or past the limit, so a smaller divider set mid-count never waits a full wrap
  assign step = cif.run & cif.tick & (pre_ff >= pre_limit(cif.psc));
  assign cif.count = cnt_ff;
  assign cif.underflow = uf_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_ff <= '0;
    end else if (cif.reload) begin
      pre_ff <= '0;
    end else if (cif.run & cif.tick) begin
      pre_ff <= step ? '0 : PRE_W'(pre_ff + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= RELOAD_RST;
    end else if (cif.reload) begin
      cnt_ff <= cif.reload_val;
    end else if (step) begin
      cnt_ff <= (cnt_ff == '0) ? cif.reload_val : CNT_W'(cnt_ff - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      uf_ff <= 1'b0;
    end else begin
      uf_ff <= step & (cnt_ff == '0) & ~cif.reload;
    end
  end
endmodule
`default_nettype wire

// >>> core/wwd_top.sv
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module wwd_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wwd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic low_speed_internal_oscillator,
  input wire logic cpu_debug,
  output logic irq,
  output logic sys_rst_req
);
  import wwd_pkg::*;

  wwd_if cif();

  logic [2:0] lsi_sync_ff;
  logic lsi_level_ff;
  logic tick_ff;
  logic en_ff;
  logic dbg_halt_ff;
  logic [PSC_W-1:0] psc_ff;
  logic [CNT_W-1:0] reload_ff;
  logic [CNT_W-1:0] delta_ff;
  logic prot_ff;
  logic [ST_W-1:0] status_ff;
  logic [ST_W-1:0] mask_ff;
  logic pready_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic irq_ff;
  logic rst_req_ff;

  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic cfg_addr;
  logic cfg_wr_ok;
  logic kick;
  logic early;
  logic [ST_W-1:0] st_set;
  logic [ST_W-1:0] st_clr;
  logic [ST_W-1:0] nxt_status;
  logic [ST_W-1:0] nxt_mask;

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_CTRL, OFS_RELOAD, OFS_DELTA, OFS_KICK,
      OFS_PROT, OFS_COUNT, OFS_STATUS, OFS_MASK: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  // Oscillator pin crosses into clk; its rising edge is one tick
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lsi_sync_ff <= '0;
      lsi_level_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      lsi_sync_ff <= {lsi_sync_ff[1:0], low_speed_internal_oscillator};
      if (lsi_sync_ff[1] == lsi_sync_ff[2]) begin
        lsi_level_ff <= lsi_sync_ff[2];
      end
      tick_ff <= (lsi_sync_ff[1] == lsi_sync_ff[2]) & lsi_sync_ff[2] & ~lsi_level_ff;
    end
  end

  assign setup = psel & ~penable;
  assign access = psel & penable & pready_ff;
  assign wr = access & pwrite & ~pslverr_ff;
  assign mapped = addr_mapped(paddr);
  assign cfg_addr = (paddr == OFS_CTRL) | (paddr == OFS_RELOAD) | (paddr == OFS_DELTA);
  assign cfg_wr_ok = wr & cfg_addr & ~prot_ff;
  // Wrong key or a stopped watchdog leaves the counter alone
  assign kick = wr & (paddr == OFS_KICK) & (pwdata[15:0] == KICK_KEY) & en_ff;
  // Count equal to delta already lies inside the window
  assign early = kick & (cif.count > delta_ff);

  assign cif.tick = tick_ff;
  // Halt freezes the prescaler too, so counting resumes in phase
  assign cif.run = en_ff & ~(dbg_halt_ff & cpu_debug);
  assign cif.reload = kick & ~early;
  assign cif.psc = psc_ff;
  assign cif.reload_val = reload_ff;

  wwd_counter u_counter (
    .clk(clk),
    .rst_b(rst_b),
    .cif(cif)
  );

  // Configuration registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_ff <= 1'b0;
      dbg_halt_ff <= 1'b0;
      psc_ff <= PSC_RST;
      reload_ff <= RELOAD_RST;
      delta_ff <= DELTA_RST;
    end else if (cfg_wr_ok) begin
      case (paddr)
        OFS_CTRL: begin
          en_ff <= pwdata[CTRL_EN_BIT];
          dbg_halt_ff <= pwdata[CTRL_DBG_BIT];
          psc_ff <= pwdata[CTRL_PSC_LSB +: PSC_W];
        end
        OFS_RELOAD: begin
          reload_ff <= pwdata[CNT_W-1:0];
        end
        OFS_DELTA: begin
          delta_ff <= pwdata[CNT_W-1:0];
        end
        default: begin
          en_ff <= en_ff;
        end
      endcase
    end
  end

  // Protection switch only moves with the key in the upper half
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prot_ff <= 1'b0;
    end else if (wr & (paddr == OFS_PROT) & (pwdata[PROT_KEY_LSB +: 16] == PROT_KEY)) begin
      prot_ff <= pwdata[0];
    end
  end

  // Sticky events: set beats the read clear in the same cycle
  always_comb begin
    st_set = '0;
    st_set[ST_UNDERFLOW] = cif.underflow;
    st_set[ST_EARLY] = early;
    st_set[ST_LOCKED_WR] = wr & cfg_addr & prot_ff;
    // Read clears only the bits it reported; an event landing in the
    // setup cycle stays pending for the next read
    st_clr = '0;
    if (access & ~pwrite & (paddr == OFS_STATUS)) begin
      st_clr = prdata_ff[ST_W-1:0];
    end
    nxt_status = (status_ff & ~st_clr) | st_set;
    nxt_mask = (wr & (paddr == OFS_MASK)) ? pwdata[ST_W-1:0] : mask_ff;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_ff <= '0;
      mask_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      irq_ff <= |(nxt_status & nxt_mask);
    end
  end

  // One-cycle request to the system reset controller
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_req_ff <= 1'b0;
    end else begin
      rst_req_ff <= cif.underflow | early;
    end
  end

  // APB slave: one wait-free access phase, data staged in setup
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else if (setup) begin
      pready_ff <= 1'b1;
      pslverr_ff <= ~mapped;
      prdata_ff <= '0;
      if (!pwrite) begin
        case (paddr)
          OFS_CTRL: begin
            prdata_ff[CTRL_EN_BIT] <= en_ff;
            prdata_ff[CTRL_DBG_BIT] <= dbg_halt_ff;
            prdata_ff[CTRL_PSC_LSB +: PSC_W] <= psc_ff;
          end
          OFS_RELOAD: prdata_ff[CNT_W-1:0] <= reload_ff;
          OFS_DELTA: prdata_ff[CNT_W-1:0] <= delta_ff;
          OFS_PROT: prdata_ff[0] <= prot_ff;
          OFS_COUNT: prdata_ff[CNT_W-1:0] <= cif.count;
          OFS_STATUS: prdata_ff[ST_W-1:0] <= status_ff;
          OFS_MASK: prdata_ff[ST_W-1:0] <= mask_ff;
          default: prdata_ff <= '0;
        endcase
      end
    end else if (access) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign pready = pready_ff;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
  assign sys_rst_req = rst_req_ff;
endmodule
`default_nettype wire

// >>> test/wwd_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module wwd_top_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wwd_pkg::ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic low_speed_internal_oscillator,
  input wire logic irq,
  input wire logic sys_rst_req
);
  import wwd_pkg::*;
  logic [3:0] since_ff;
  wire acc = psel && penable && pready;
  wire kick = acc && pwrite && paddr == OFS_KICK;
  wire clr = acc && (paddr == OFS_STATUS || paddr == OFS_MASK);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Age of last slow edge; a reset request needs a recent one or a kick
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) since_ff <= 4'hf;
    else if ($rose(low_speed_internal_oscillator)) since_ff <= 4'h0;
    else if (since_ff != 4'hf) since_ff <= since_ff + 4'h1;
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("late");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("long");
  a_no_stray_ready: assert property (!(psel && !penable) |=> !pready) else $error("stray");
  a_err_decode: assert property (pready |-> pslverr == (paddr > 8'h1c || paddr[1:0] != 2'h0))
    else $error("decode");
  a_write_data_zero: assert property (pready && pwrite |-> prdata == 32'h0) else $error("wdata");
  a_rst_one_pulse: assert property (sys_rst_req |=> !sys_rst_req) else $error("pulse");
  a_rst_has_cause: assert property (sys_rst_req |-> $past(kick) || since_ff <= 4'ha)
    else $error("cause");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(clr) || $past(clr, 2))
    else $error("irq");
  c_rst: cover property (sys_rst_req);
  c_irq: cover property (irq);
  c_err: cover property (pready && pslverr);
endmodule
bind wwd_top wwd_top_asserts chk (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .low_speed_internal_oscillator(low_speed_internal_oscillator), .irq(irq),
  .sys_rst_req(sys_rst_req));
`default_nettype wire

// >>> test/windowed_watchdog_test.sv
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_test;
  import wwd_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, osc, dbg, pready, pslverr, irq, srr, err_v;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [11:0] r;
  logic [PSC_W-1:0] p;
  int bad_count, tests_run, pulses, cyc;
  wwd_top dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .low_speed_internal_oscillator(osc), .cpu_debug(dbg), .irq(irq), .sys_rst_req(srr));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic test_done();
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (srr === 1'b1) pulses++;
    if (cyc == 5000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Slow ticks per counter step for a divider setting
  function automatic int tick_div(input logic [PSC_W-1:0] ps);
    tick_div = 1 << ps;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No cycle budget here; a hang ends at the bench timeout
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_v, e);
  endtask
  // Slow pin kept well above the two-clock minimum each way
  task automatic tick(input int n);
    repeat (n) begin
      osc <= 1'b1;
      repeat (4) @(posedge clk);
      osc <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask
  initial begin
    {rst_b, psel, penable, pwrite, osc, dbg} <= 6'h0;
    paddr <= 8'h0;
    pwdata <= 32'h0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    void'($urandom(42428));
    r = 12'($urandom_range(40, 8));
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_RELOAD, 32'hfff);
    rdc(OFS_DELTA, 32'hfff);
    rdc(OFS_COUNT, 32'hfff);
    chk_bit(err_v, 1'b0);
    apb(1'b0, 8'h24, 32'h0);
    chk_bit(err_v, 1'b1);
    $display("test reset done");
    wr(OFS_RELOAD, r);
    wr(OFS_MASK, 32'h7);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_KICK, KICK_KEY);
    rdc(OFS_COUNT, r);
    tick(3);
    rdc(OFS_COUNT, r - 3);
    repeat (50) @(posedge clk);
    rdc(OFS_COUNT, r - 3);
    tick(r - 3);
    chk(pulses, 0);
    tick(1);
    chk(pulses, 1);
    chk_bit(irq, 1'b1);
    rdc(OFS_STATUS, 32'h1);
    rdc(OFS_COUNT, r);
    chk_bit(irq, 1'b0);
    $display("test underflow done");
    // Second kick after one tick must restart the prescaler phase
    wr(OFS_CTRL, 32'h11);
    wr(OFS_KICK, KICK_KEY);
    tick(1);
    wr(OFS_KICK, KICK_KEY);
    tick(1);
    rdc(OFS_COUNT, r);
    tick(1);
    rdc(OFS_COUNT, r - 1);
    wr(OFS_CTRL, 32'h111);
    dbg <= 1'b1;
    tick(4);
    rdc(OFS_COUNT, r - 1);
    dbg <= 1'b0;
    tick(2);
    rdc(OFS_COUNT, r - 2);
    $display("test prescale done");
    wr(OFS_DELTA, r - 3);
    wr(OFS_KICK, KICK_KEY);
    rdc(OFS_COUNT, r - 2);
    chk(pulses, 2);
    rdc(OFS_STATUS, 32'h2);
    wr(OFS_DELTA, r - 2);
    wr(OFS_KICK, KICK_KEY);
    rdc(OFS_COUNT, r);
    $display("test window done");
    wr(OFS_MASK, 32'h0);
    wr(OFS_PROT, {PROT_KEY, 16'h1});
    wr(OFS_DELTA, 32'h5);
    rdc(OFS_DELTA, r - 2);
    chk_bit(irq, 1'b0);
    rdc(OFS_STATUS, 32'h4);
    wr(OFS_PROT, {PROT_KEY, 16'h0});
    wr(OFS_DELTA, 32'h5);
    rdc(OFS_DELTA, 32'h5);
    $display("test protect done");
    // Random divider, then keys that must be refused
    p = PSC_W'($urandom_range(3, 0));
    wr(OFS_CTRL, 32'h1 | (32'(p) << CTRL_PSC_LSB));
    wr(OFS_DELTA, r);
    wr(OFS_KICK, KICK_KEY);
    tick(tick_div(p) - 1);
    rdc(OFS_COUNT, r);
    tick(1);
    rdc(OFS_COUNT, r - 1);
    wr(OFS_KICK, KICK_KEY ^ 16'h1);
    rdc(OFS_COUNT, r - 1);
    wr(OFS_PROT, 32'h1);
    wr(OFS_DELTA, 32'h7);
    rdc(OFS_DELTA, 32'h7);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_KICK, KICK_KEY);
    rdc(OFS_COUNT, r - 1);
    chk(pulses, 2);
    $display("test keys done");
    test_done();
  end
endmodule
`default_nettype wire
